/* bridge_driver_status_regs.v */
// read-only bridge driver status registers with reset and restart behaviour
//
// Behaviour
// - reserved status bits always read zero
// - bit 5+n shows bridge output high level
// - output flag zero unless pump on, mode 11
// - reset clears all; restart keeps bits 7,6,0
// - predischarge flag zero when clamped, agc 1x, pwm on, not hiz
// - bit 7 zero when bridge4 discharge clamped, agc 1x, pwm4 on, not hiz
// - clamp flags one when pwm off, hiz, agc 0x
// - bit n-1 shows bridge delay in regulation
`timescale 1ns/1ps
`include "bridge_status_defines.vh"
module bridge_driver_status_regs
#(
   parameter NUM_BRIDGES = 4
)
(
   // clock and reset
   input  wire        CLOCK_I,
   input  wire        NRST_I,
   input  wire        RESTART_I,
   // register read port
   input  wire [6:0]  READ_ADDR_I,
   output reg  [15:0] READ_DATA_O,
   // configuration from the control registers
   input  wire        CHARGE_PUMP_ENABLE_I,
   input  wire [7:0]  BRIDGE_MODE_FIELD_I,
   input  wire [1:0]  ADAPTIVE_GATE_CONTROL_FIELD_I,
   input  wire [3:0]  BRIDGE_PWM_ENABLE_I,
   input  wire [3:0]  BRIDGE_HIGH_IMPEDANCE_I,
   // analog comparator levels
   input  wire [3:0]  BRIDGE_OUTPUT_SENSE_I,
   input  wire [3:0]  PREDISCHARGE_AT_LIMIT_I,
   input  wire        DISCHARGE4_AT_LIMIT_I,
   input  wire [3:0]  DELAY_IN_REGULATION_I,
   // pwm pins
   input  wire        FIRST_PWM_PIN_I,
   input  wire        SECOND_PWM_PIN_I
);
   wire [3:0]  sense_sync;
   wire [3:0]  clamp_sync;
   wire        dis4_sync;
   wire [3:0]  reg_sync;
   wire [1:0]  pwm_sync;
   reg  [15:0] gen_reg;
   reg  [15:0] gen_next;
   reg  [15:0] dreg_reg;
   reg  [15:0] dreg_next;
   integer     n;

   // clamp status may only read 0 when adaptive control active and pwm on
   function clamp_bit;
      input at_limit;
      input agc_hi;
      input pwm_en;
      input hiz;
      begin
         clamp_bit = ~(at_limit & agc_hi & pwm_en & ~hiz);
      end
   endfunction

   // adaptive gate control counts as active for codes 10 and 11 only
   function agc_adaptive;
      input [1:0] adaptive_gate_control_field;
      begin
         agc_adaptive = (adaptive_gate_control_field[1] == `AGC_ADAPTIVE_HI);
      end
   endfunction

   // fifteen pin levels: 4 sense, 4 predischarge, 1 discharge, 4 regulation, 2 pwm
   status_input_sync #(.WIDTH(15)) u_sync
   (
      .clk      (CLOCK_I),
      .nrst     (NRST_I),
      .async_in ({BRIDGE_OUTPUT_SENSE_I, PREDISCHARGE_AT_LIMIT_I, DISCHARGE4_AT_LIMIT_I,
                  DELAY_IN_REGULATION_I, SECOND_PWM_PIN_I, FIRST_PWM_PIN_I}),
      .sync_out ({sense_sync, clamp_sync, dis4_sync, reg_sync, pwm_sync})
   );

   always @*
   begin
      gen_next  = `STATUS_RESET_VALUE;
      dreg_next = `STATUS_RESET_VALUE;
      for (n = 0; n < NUM_BRIDGES; n = n + 1)
      begin
         gen_next[`GEN_OUT_LEVEL_LSB + n] = CHARGE_PUMP_ENABLE_I
            & (BRIDGE_MODE_FIELD_I[2*n +: 2] == `BRIDGE_MODE_ACTIVE)
            & sense_sync[n];
         dreg_next[`DREG_PREDISCHARGE_LSB + n] = clamp_bit(clamp_sync[n],
            agc_adaptive(ADAPTIVE_GATE_CONTROL_FIELD_I),
            BRIDGE_PWM_ENABLE_I[n], BRIDGE_HIGH_IMPEDANCE_I[n]);
         dreg_next[`DREG_REGULATION_LSB + n] = reg_sync[n];
      end
      dreg_next[`DREG_DISCHARGE_BIT] = clamp_bit(dis4_sync,
         agc_adaptive(ADAPTIVE_GATE_CONTROL_FIELD_I),
         BRIDGE_PWM_ENABLE_I[3], BRIDGE_HIGH_IMPEDANCE_I[3]);
      gen_next[`GEN_SECOND_PWM_BIT] = pwm_sync[1];
      gen_next[`GEN_FIRST_PWM_BIT]  = pwm_sync[0];
      // restart clears all but the bits that keep their current state
      if (RESTART_I)
      begin
         gen_next  = gen_next  & `GEN_RESTART_KEEP_MASK;
         dreg_next = dreg_next & `DREG_RESTART_KEEP_MASK;
      end
   end

   always @(posedge CLOCK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         gen_reg  <= `STATUS_RESET_VALUE;
         dreg_reg <= `STATUS_RESET_VALUE;
      end
      else
      begin
         gen_reg  <= gen_next;
         dreg_reg <= dreg_next;
      end
   end

   always @*
   begin
      case (READ_ADDR_I)
         `BRIDGE_GENERAL_STATUS_ADDR:        READ_DATA_O = gen_reg;
         `GATE_DELAY_REGULATION_STATUS_ADDR: READ_DATA_O = dreg_reg;
         default:                            READ_DATA_O = `STATUS_RESET_VALUE;
      endcase
   end
endmodule

/* bridge_status_defines.vh */
// constants for the bridge driver status registers
`ifndef BRIDGE_STATUS_DEFINES_VH
`define BRIDGE_STATUS_DEFINES_VH
`define BRIDGE_GENERAL_STATUS_ADDR        7'h50
`define GATE_DELAY_REGULATION_STATUS_ADDR 7'h51
`define GEN_OUT_LEVEL_LSB                 6
`define GEN_SECOND_PWM_BIT                2
`define GEN_FIRST_PWM_BIT                 0
`define DREG_PREDISCHARGE_LSB             8
`define DREG_DISCHARGE_BIT                7
`define DREG_REGULATION_LSB               0
`define STATUS_RESET_VALUE                16'h0000
`define GEN_RESTART_KEEP_MASK             16'h00c1
`define DREG_RESTART_KEEP_MASK            16'h00c1
`define BRIDGE_MODE_ACTIVE                2'h3
`define AGC_ADAPTIVE_HI                   1'b1
`endif

/* status_input_sync.v */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module status_input_sync
#(
   parameter WIDTH = 2
)
(
   input  wire             clk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;
endmodule

/* host_reader.sv */
// host model reading status words over the address port
`timescale 1ns/1ps
module host_reader(
   input  wire logic        CLOCK_I,
   input  wire logic [15:0] READ_DATA_O,
   output logic      [6:0]  READ_ADDR_I);
   initial READ_ADDR_I = 7'h50;
   task rd(input logic [6:0] a, output logic [15:0] d);
      @(negedge CLOCK_I);
      READ_ADDR_I = a;
      #1 d = READ_DATA_O;
   endtask
endmodule

/* bridge_status_monitor.sv */
// assertion checker for the bridge status registers
`timescale 1ns/1ps
module bridge_status_monitor(
   input wire logic CLOCK_I, NRST_I, RESTART_I, CHARGE_PUMP_ENABLE_I, DISCHARGE4_AT_LIMIT_I,
   input wire logic FIRST_PWM_PIN_I, SECOND_PWM_PIN_I,
   input wire logic [6:0] READ_ADDR_I,
   input wire logic [15:0] READ_DATA_O,
   input wire logic [7:0] BRIDGE_MODE_FIELD_I,
   input wire logic [1:0] ADAPTIVE_GATE_CONTROL_FIELD_I,
   input wire logic [3:0] BRIDGE_PWM_ENABLE_I, BRIDGE_HIGH_IMPEDANCE_I, BRIDGE_OUTPUT_SENSE_I,
   input wire logic [3:0] PREDISCHARGE_AT_LIMIT_I, DELAY_IN_REGULATION_I);
   wire g = READ_ADDR_I == 7'h50;
   wire t = READ_ADDR_I == 7'h51;
   wire a1 = ADAPTIVE_GATE_CONTROL_FIELD_I[1];
   wire [7:0] m = BRIDGE_MODE_FIELD_I;
   wire [3:0] hz = BRIDGE_HIGH_IMPEDANCE_I;
   wire [3:0] on = {&m[7:6], &m[5:4], &m[3:2], &m[1:0]} & {4{CHARGE_PUMP_ENABLE_I}};
   wire [4:0] cl = ~({PREDISCHARGE_AT_LIMIT_I & BRIDGE_PWM_ENABLE_I & ~hz,
      DISCHARGE4_AT_LIMIT_I & BRIDGE_PWM_ENABLE_I[3] & ~hz[3]} & {5{a1}});
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   // all inputs held, no restart, long enough to pass the synchroniser
   sequence calm;
      (!RESTART_I && $stable({m, a1, hz, on, cl, BRIDGE_OUTPUT_SENSE_I, DELAY_IN_REGULATION_I,
         FIRST_PWM_PIN_I, SECOND_PWM_PIN_I}))[*4];
   endsequence
   a_gen_reserved: assert property (g |-> (READ_DATA_O & 16'hfc3a) == 16'h0000)
      else $error("general reserved bit set");
   a_dreg_reserved: assert property (t |-> READ_DATA_O[15:12] == 4'h0)
      else $error("delay reserved bit set");
   a_level_live: assert property (calm ##0 g |-> READ_DATA_O[9:6] == (on & BRIDGE_OUTPUT_SENSE_I))
      else $error("output level wrong");
   a_level_forced: assert property ((!CHARGE_PUMP_ENABLE_I)[*2] ##0 g |-> READ_DATA_O[9:6] == 4'h0)
      else $error("output level not forced");
   a_pin_levels: assert property (calm ##0 g |-> READ_DATA_O[2] == SECOND_PWM_PIN_I
      && READ_DATA_O[0] == FIRST_PWM_PIN_I) else $error("pwm pin level wrong");
   a_restart_clear: assert property (RESTART_I[*2] ##0 g |-> (READ_DATA_O & 16'hff3e) == 16'h0000)
      else $error("restart left bits set");
   a_clamp_live: assert property (calm ##0 t |-> READ_DATA_O[11:7] == cl)
      else $error("clamp flag wrong");
   a_clamp_idle: assert property ((!a1 && !RESTART_I)[*2] ##0 t |-> READ_DATA_O[11:7] == 5'h1f)
      else $error("idle clamp flag low");
   a_delay_reg: assert property (calm ##0 t |-> READ_DATA_O[3:0] == DELAY_IN_REGULATION_I)
      else $error("regulation flag wrong");
endmodule
bind bridge_driver_status_regs bridge_status_monitor mon_u (.*);

/* bridge_driver_status_regs_tb.sv */
// self-checking bench for the bridge status registers
`timescale 1ns/1ps
module bridge_driver_status_regs_tb;
   logic CLOCK_I = 0, NRST_I = 0, RESTART_I = 0, CHARGE_PUMP_ENABLE_I = 0, DISCHARGE4_AT_LIMIT_I = 0;
   logic FIRST_PWM_PIN_I = 0, SECOND_PWM_PIN_I = 0;
   logic [7:0] BRIDGE_MODE_FIELD_I = 0;
   logic [1:0] ADAPTIVE_GATE_CONTROL_FIELD_I = 0;
   logic [3:0] BRIDGE_PWM_ENABLE_I = 0, BRIDGE_HIGH_IMPEDANCE_I = 0, BRIDGE_OUTPUT_SENSE_I = 0;
   logic [3:0] PREDISCHARGE_AT_LIMIT_I = 0, DELAY_IN_REGULATION_I = 0;
   wire [6:0] READ_ADDR_I;
   wire [15:0] READ_DATA_O;
   int error_cnt = 0, samples_checked = 0;
   bridge_driver_status_regs dut_u (.*);
   host_reader host_u (.*);
   initial forever #50 CLOCK_I = ~CLOCK_I;
   task rd_cmp(input logic [6:0] a, input logic [15:0] mk, e);
      logic [15:0] d;
      host_u.rd(a, d);
      samples_checked++;
      if ((d & mk) !== e) begin error_cnt++; $display("Error reg %h exp %h got %h", a, e, d); end
   endtask
   task settle; repeat (5) @(negedge CLOCK_I); endtask
   task t_level;
      {CHARGE_PUMP_ENABLE_I, BRIDGE_MODE_FIELD_I, BRIDGE_OUTPUT_SENSE_I} = {1'b1, 8'he4, 4'hf};
      FIRST_PWM_PIN_I = 1;
      settle; rd_cmp(7'h50, 16'hffff, 16'h0201);
      {CHARGE_PUMP_ENABLE_I, FIRST_PWM_PIN_I, SECOND_PWM_PIN_I} = 3'b001;
      settle; rd_cmp(7'h50, 16'hffff, 16'h0004);
      rd_cmp(7'h52, 16'hffff, 16'h0000);
   endtask
   task t_clamp;
      {BRIDGE_PWM_ENABLE_I, BRIDGE_HIGH_IMPEDANCE_I, PREDISCHARGE_AT_LIMIT_I} = 12'hf2f;
      {DISCHARGE4_AT_LIMIT_I, DELAY_IN_REGULATION_I} = 5'h15;
      for (int i = 0; i < 4; i++) begin
         ADAPTIVE_GATE_CONTROL_FIELD_I = i[1:0];
         settle; rd_cmp(7'h51, 16'hff8f, i < 2 ? 16'h0f85 : 16'h0205);
      end
      BRIDGE_PWM_ENABLE_I = 4'h7;
      settle; rd_cmp(7'h51, 16'hff8f, 16'h0a85);
   endtask
   task t_restart;
      {CHARGE_PUMP_ENABLE_I, BRIDGE_MODE_FIELD_I, FIRST_PWM_PIN_I, SECOND_PWM_PIN_I} = 11'h7ff;
      RESTART_I = 1;
      settle; rd_cmp(7'h50, 16'hffff, 16'h00c1);
      RESTART_I = 0;
      settle; rd_cmp(7'h50, 16'hffff, 16'h03c5);
   endtask
   task give_verdict;
      if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      rd_cmp(7'h50, 16'hffff, 16'h0000);
      rd_cmp(7'h51, 16'hffff, 16'h0000);
      repeat (2) @(negedge CLOCK_I);
      NRST_I = 1;
      t_level; t_clamp; t_restart;
      give_verdict;
   end
endmodule
